// [common/timer_flag_pkg.sv]
// Shared constants for the timer status, interrupt enable and PWM level block
package timer_flag_pkg;

  // Channel count and flag layout
  localparam int NUM_CH = 2;            // Two timer channels
  localparam int NUM_CMP = 4;           // Compare registers A to D per channel
  localparam int NUM_FLAGS = 6;         // Match/capture A-D, overflow, underflow
  localparam int CH_UNDER = 1;          // Only this channel owns an underflow flag
  localparam int NUM_PWM = 3;           // PWM outputs B, C, D

  // Status register bit positions
  localparam int BIT_OVER = 4;
  localparam int BIT_UNDER = 5;
  // Enable register bit positions
  localparam int BIT_OVER_EN = 4;

  // CPU access port
  localparam int ADDR_W = 5;
  localparam int WIDE_W = 16;
  localparam int BYTE_W = 8;
  localparam int WIDE_IDX_W = 4;
  typedef logic [ADDR_W-1:0] reg_index_t;

  // Byte register indices
  localparam reg_index_t IDX_STATUS_CH0 = 5'h00;
  localparam reg_index_t IDX_STATUS_CH1 = 5'h01;
  localparam reg_index_t IDX_IER_CH0 = 5'h02;
  localparam reg_index_t IDX_IER_CH1 = 5'h03;
  localparam reg_index_t IDX_POL_CH0 = 5'h04;
  localparam reg_index_t IDX_POL_CH1 = 5'h05;
  // Wide window: counter then A-D, channel 0 first
  localparam reg_index_t IDX_WIDE_FIRST = 5'h10;
  localparam reg_index_t IDX_WIDE_LAST = 5'h19;

  // Reserved bits read as one
  localparam logic [7:0] STATUS_RSVD = 8'hC0;
  localparam logic [7:0] STATUS_RSVD_NO_UDF = 8'hE0;
  localparam logic [7:0] IER_RSVD = 8'hE0;
  localparam logic [7:0] POL_RSVD = 8'hF8;

  // Reset values
  localparam logic [NUM_FLAGS-1:0] FLAGS_RESET = 6'h00;
  localparam logic [4:0] IER_RESET = 5'h00;
  localparam logic [NUM_PWM-1:0] POL_RESET = 3'h0;
  localparam logic PWM_LEVEL_RESET = 1'b0;
  localparam logic [WIDE_W-1:0] RDATA_RESET = 16'h0000;

endpackage : timer_flag_pkg

// [rtl/flag_cell.sv]
// One sticky status flag with read-one-then-write-zero clearing
`timescale 1ns/1ps
`default_nettype none
module flag_cell
  import timer_flag_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic set_event,     // Hardware event that sets the flag
  input wire logic reg_read,      // Owning register read this cycle
  input wire logic reg_write,     // Owning register written this cycle
  input wire logic write_bit,     // Data bit written to this flag
  output logic flag               // Current flag value
);

  logic armed;        // Flag was read as one since the last write
  logic next_flag;
  logic next_armed;

  ////////////////////////////////////////////////////////////////////////
  // Next state: a set event beats a clear in the same cycle
  always_comb
  begin
    next_flag = flag;
    next_armed = armed;
    if (reg_write)
    begin
      // A write consumes the arm whatever the data
      next_armed = 1'b0;
      if (armed && !write_bit)
      begin
        next_flag = 1'b0;
      end
    end
    else if (reg_read)
    begin
      // Only a read that saw a one may later clear
      next_armed = flag;
    end
    if (set_event)
    begin
      next_flag = 1'b1;
    end
  end

  // Registers
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      flag <= 1'b0;
      armed <= 1'b0;
    end
    else
    begin
      flag <= next_flag;
      armed <= next_armed;
    end
  end

endmodule : flag_cell
`default_nettype wire

// [rtl/pwm_level_cell.sv]
// One PWM output level driven by period and duty compare matches
`timescale 1ns/1ps
`default_nettype none
module pwm_level_cell
  import timer_flag_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic pwm_enable,    // Channel is in PWM mode
  input wire logic period_match,  // Compare match A
  input wire logic duty_match,    // Compare match of this output's register
  input wire logic active_high,   // Polarity bit for this output
  output logic level              // Pin level
);

  logic next_level;

  ////////////////////////////////////////////////////////////////////////
  // Duty match drives the active level, period match the inactive one
  // Duty wins on a tie so a zero-width duty still gives a pulse edge
  always_comb
  begin
    next_level = level;
    if (pwm_enable)
    begin
      if (duty_match)
      begin
        next_level = active_high;
      end
      else if (period_match)
      begin
        next_level = !active_high;
      end
    end
  end

  // Register
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      level <= PWM_LEVEL_RESET;
    end
    else
    begin
      level <= next_level;
    end
  end

endmodule : pwm_level_cell
`default_nettype wire

// [rtl/timer_flag_irq_polarity_regs.sv]
// Status flags, interrupt enables, PWM polarity and CPU access of a two-channel timer
//
// Behaviour
// RULE1: Status, enable, polarity register per channel
// RULE2: Compare match sets flag in compare mode
// RULE3: Capture sets flag in capture mode
// RULE4: Flag clears by read one, write zero
// RULE5: Status bits: underflow, overflow, D to A
// RULE6: Underflow only channel 1; else reads one
// RULE7: Reserved register bits always read one
// RULE8: Set flag with enable raises request
// RULE9: Overflow enable gates overflow or underflow
// RULE10: Enable bits 3-0 gate match requests
// RULE11: Polarity bits pick active level D,C,B
// RULE12: Counter and general registers: 16-bit only
// RULE13: Other registers are 8-bit wide
// RULE14: Overflow sets flag, count resumes at zero
// RULE15: Polarity 0: B low on B, high on A
// RULE16: Set wins over simultaneous clear
`timescale 1ns/1ps
`default_nettype none
module timer_flag_irq_polarity_regs
  import timer_flag_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  // CPU access
  input wire logic [ADDR_W-1:0] cpu_addr,
  input wire logic cpu_rd,
  input wire logic cpu_wr,
  input wire logic cpu_wide,
  input wire logic [WIDE_W-1:0] cpu_wdata,
  output logic [WIDE_W-1:0] cpu_rdata,
  output logic cpu_rvalid,
  output logic cpu_refused,
  output logic cpu_busy,
  // Wide registers held by the counter logic
  output logic wide_rd,
  output logic wide_wr,
  output logic [WIDE_IDX_W-1:0] wide_index,
  output logic [WIDE_W-1:0] wide_wdata,
  input wire logic [WIDE_W-1:0] wide_rdata,
  // Counter events
  input wire logic [NUM_CH-1:0][NUM_CMP-1:0] compare_match,
  input wire logic [NUM_CH-1:0][NUM_CMP-1:0] capture_event,
  input wire logic [NUM_CH-1:0][NUM_CMP-1:0] cmp_is_capture,
  input wire logic [NUM_CH-1:0] counter_overflow,
  input wire logic channel1_counter_underflow,
  input wire logic [NUM_CH-1:0] pwm_mode,
  // Interrupt requests
  output logic [NUM_CH-1:0] overflow_irq_request,
  output logic [NUM_CH-1:0] match_irq_request_a,
  output logic [NUM_CH-1:0] match_irq_request_b,
  output logic [NUM_CH-1:0] match_irq_request_c,
  output logic [NUM_CH-1:0] match_irq_request_d,
  // PWM pins
  output logic [NUM_CH-1:0] wave_pin_b,
  output logic [NUM_CH-1:0] wave_pin_c,
  output logic [NUM_CH-1:0] wave_pin_d
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  typedef enum logic [0:0] {
    acc_idle,                   // Ready for a new access
    acc_wide_read               // Waiting one cycle for wide read data
  } acc_state_e;

  acc_state_e acc_state;        // Access sequencer state
  acc_state_e next_acc_state;

  // Per channel flags, bits 3..0 match/capture, 4 overflow, 5 underflow
  logic [NUM_CH-1:0][NUM_FLAGS-1:0] flags;
  logic [NUM_CH-1:0][NUM_FLAGS-1:0] flag_set;
  logic [NUM_CH-1:0] status_read;   // Status register read taken
  logic [NUM_CH-1:0] status_write;  // Status register write taken

  // Enable and polarity registers, reserved bits not stored
  logic [NUM_CH-1:0][4:0] irq_enable;
  logic [NUM_CH-1:0][4:0] next_irq_enable;
  logic [NUM_CH-1:0][NUM_PWM-1:0] pwm_polarity;
  logic [NUM_CH-1:0][NUM_PWM-1:0] next_pwm_polarity;

  // Access decode
  logic accept;                 // Request seen while idle
  logic is_wide_reg;            // Address in the 16-bit window
  logic is_byte_reg;            // Address of an 8-bit register
  logic [BYTE_W-1:0] byte_value;

  // Next values of registered outputs
  logic [WIDE_W-1:0] next_cpu_rdata;
  logic next_cpu_rvalid;
  logic next_cpu_refused;
  logic next_wide_rd;
  logic next_wide_wr;
  logic [WIDE_IDX_W-1:0] next_wide_index;
  logic [WIDE_W-1:0] next_wide_wdata;
  logic [NUM_CH-1:0] next_over_req;
  logic [NUM_CH-1:0][NUM_CMP-1:0] next_match_req;

  ////////////////////////////////////////////////////////////////////////
  // Address decode, one register set per channel
  always_comb
  begin
    accept = (acc_state == acc_idle) && (cpu_rd || cpu_wr);
    is_wide_reg = (cpu_addr >= IDX_WIDE_FIRST) && (cpu_addr <= IDX_WIDE_LAST);
    is_byte_reg = (cpu_addr <= IDX_POL_CH1); // RULE1
    status_read[0] = accept && cpu_rd && (cpu_addr == IDX_STATUS_CH0);
    status_read[1] = accept && cpu_rd && (cpu_addr == IDX_STATUS_CH1);
    status_write[0] = accept && cpu_wr && (cpu_addr == IDX_STATUS_CH0);
    status_write[1] = accept && cpu_wr && (cpu_addr == IDX_STATUS_CH1);
  end

  ////////////////////////////////////////////////////////////////////////
  // Byte register read value, reserved bits forced to one
  always_comb
  begin
    case (cpu_addr)
      IDX_STATUS_CH0: byte_value = STATUS_RSVD_NO_UDF | {2'h0, 1'b0, flags[0][BIT_OVER:0]}; // RULE6 RULE7
      IDX_STATUS_CH1: byte_value = STATUS_RSVD | {2'h0, flags[1]}; // RULE5 RULE7
      IDX_IER_CH0: byte_value = IER_RSVD | {3'h0, irq_enable[0]}; // RULE7
      IDX_IER_CH1: byte_value = IER_RSVD | {3'h0, irq_enable[1]}; // RULE7
      IDX_POL_CH0: byte_value = POL_RSVD | {5'h00, pwm_polarity[0]}; // RULE7
      IDX_POL_CH1: byte_value = POL_RSVD | {5'h00, pwm_polarity[1]}; // RULE7
      default: byte_value = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Flag set sources; capture or compare chosen by the register's mode
  always_comb
  begin
    for (int ch = 0; ch < NUM_CH; ch++)
    begin
      for (int g = 0; g < NUM_CMP; g++)
      begin
        // RULE2 RULE3
        flag_set[ch][g] = cmp_is_capture[ch][g] ? capture_event[ch][g] : compare_match[ch][g];
      end
      // Counter logic restarts from zero itself; only the flag lives here
      flag_set[ch][BIT_OVER] = counter_overflow[ch]; // RULE14
      flag_set[ch][BIT_UNDER] = (ch == CH_UNDER) ? channel1_counter_underflow : 1'b0; // RULE6
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Flag cells, one per channel and bit; channel 0 has no underflow cell
  for (genvar ch = 0; ch < NUM_CH; ch++)
  begin : g_ch
    for (genvar b = 0; b < NUM_FLAGS; b++)
    begin : g_flag
      if ((ch == CH_UNDER) || (b != BIT_UNDER))
      begin : g_cell
        flag_cell u_flag (
          .clock(clock),
          .srst(srst),
          .set_event(flag_set[ch][b]),
          .reg_read(status_read[ch]),    // RULE4
          .reg_write(status_write[ch]),  // RULE4
          .write_bit(cpu_wdata[b]),
          .flag(flags[ch][b])            // RULE16
        );
      end
      else
      begin : g_none
        assign flags[ch][b] = 1'b0;
      end
    end

    // PWM outputs B, C, D with compare match A as the period
    pwm_level_cell u_pwm_b (
      .clock(clock),
      .srst(srst),
      .pwm_enable(pwm_mode[ch]),
      .period_match(compare_match[ch][0]),
      .duty_match(compare_match[ch][1]),
      .active_high(pwm_polarity[ch][0]),  // RULE15
      .level(wave_pin_b[ch])
    );
    pwm_level_cell u_pwm_c (
      .clock(clock),
      .srst(srst),
      .pwm_enable(pwm_mode[ch]),
      .period_match(compare_match[ch][0]),
      .duty_match(compare_match[ch][2]),
      .active_high(pwm_polarity[ch][1]),  // RULE11
      .level(wave_pin_c[ch])
    );
    pwm_level_cell u_pwm_d (
      .clock(clock),
      .srst(srst),
      .pwm_enable(pwm_mode[ch]),
      .period_match(compare_match[ch][0]),
      .duty_match(compare_match[ch][3]),
      .active_high(pwm_polarity[ch][2]),  // RULE11
      .level(wave_pin_d[ch])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // Enable and polarity registers: byte writes, low byte of the data bus
  always_comb
  begin
    next_irq_enable = irq_enable;
    next_pwm_polarity = pwm_polarity;
    if (accept && cpu_wr)
    begin
      case (cpu_addr)
        IDX_IER_CH0: next_irq_enable[0] = cpu_wdata[4:0]; // RULE13
        IDX_IER_CH1: next_irq_enable[1] = cpu_wdata[4:0]; // RULE13
        IDX_POL_CH0: next_pwm_polarity[0] = cpu_wdata[NUM_PWM-1:0]; // RULE11
        IDX_POL_CH1: next_pwm_polarity[1] = cpu_wdata[NUM_PWM-1:0]; // RULE11
        default:
        begin
          // Other addresses leave these registers alone
        end
      endcase
    end
  end

  // Registers
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      irq_enable <= {NUM_CH{IER_RESET}};
      pwm_polarity <= {NUM_CH{POL_RESET}};
    end
    else
    begin
      irq_enable <= next_irq_enable;
      pwm_polarity <= next_pwm_polarity;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt requests, registered so each output comes from a flop
  always_comb
  begin
    for (int ch = 0; ch < NUM_CH; ch++)
    begin
      // One overflow request serves both overflow and underflow
      next_over_req[ch] = irq_enable[ch][BIT_OVER_EN] && (flags[ch][BIT_OVER] || flags[ch][BIT_UNDER]); // RULE8 RULE9
      next_match_req[ch] = irq_enable[ch][NUM_CMP-1:0] & flags[ch][NUM_CMP-1:0]; // RULE8 RULE10
    end
  end

  // Registers
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      overflow_irq_request <= '0;
      match_irq_request_a <= '0;
      match_irq_request_b <= '0;
      match_irq_request_c <= '0;
      match_irq_request_d <= '0;
    end
    else
    begin
      overflow_irq_request <= next_over_req;
      for (int ch = 0; ch < NUM_CH; ch++)
      begin
        match_irq_request_a[ch] <= next_match_req[ch][0];
        match_irq_request_b[ch] <= next_match_req[ch][1];
        match_irq_request_c[ch] <= next_match_req[ch][2];
        match_irq_request_d[ch] <= next_match_req[ch][3];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Byte reads answer next cycle, wide reads one later
  // A byte access to a wide register is refused so a half-written
  // word never reaches the counter logic
  always_comb
  begin
    next_acc_state = acc_state;
    next_cpu_rdata = cpu_rdata;
    next_cpu_rvalid = 1'b0;
    next_cpu_refused = 1'b0;
    next_wide_rd = 1'b0;
    next_wide_wr = 1'b0;
    next_wide_index = wide_index;
    next_wide_wdata = wide_wdata;
    case (acc_state)
      acc_idle:
      begin
        if (accept)
        begin
          if (is_wide_reg && cpu_wide)
          begin
            // Forward whole-word access to the counter logic
            next_wide_index = WIDE_IDX_W'(cpu_addr - IDX_WIDE_FIRST); // RULE12
            next_wide_rd = cpu_rd;
            next_wide_wr = cpu_wr && !cpu_rd;
            next_wide_wdata = cpu_wdata;
            if (cpu_rd)
            begin
              next_acc_state = acc_wide_read;
            end
          end
          else if (is_byte_reg)
          begin
            // Byte registers answer on the low byte
            if (cpu_rd)
            begin
              next_cpu_rdata = {8'h00, byte_value}; // RULE13
              next_cpu_rvalid = 1'b1;
            end
          end
          else
          begin
            // Unmapped or byte access to a wide register
            next_cpu_refused = 1'b1; // RULE12
            if (cpu_rd)
            begin
              next_cpu_rdata = RDATA_RESET;
              next_cpu_rvalid = 1'b1;
            end
          end
        end
      end
      acc_wide_read:
      begin
        // Counter logic returns data while the read strobe stands
        next_cpu_rdata = wide_rdata;
        next_cpu_rvalid = 1'b1;
        next_acc_state = acc_idle;
      end
      default:
      begin
        next_acc_state = acc_idle;
      end
    endcase
  end

  // Registers
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      acc_state <= acc_idle;
      cpu_rdata <= RDATA_RESET;
      cpu_rvalid <= 1'b0;
      cpu_refused <= 1'b0;
      cpu_busy <= 1'b0;
      wide_rd <= 1'b0;
      wide_wr <= 1'b0;
      wide_index <= '0;
      wide_wdata <= RDATA_RESET;
    end
    else
    begin
      acc_state <= next_acc_state;
      cpu_rdata <= next_cpu_rdata;
      cpu_rvalid <= next_cpu_rvalid;
      cpu_refused <= next_cpu_refused;
      cpu_busy <= (next_acc_state == acc_wide_read);
      wide_rd <= next_wide_rd;
      wide_wr <= next_wide_wr;
      wide_index <= next_wide_index;
      wide_wdata <= next_wide_wdata;
    end
  end

endmodule : timer_flag_irq_polarity_regs
`default_nettype wire

// [verification/timer_flag_monitor.sv]
// Port-level checks for the timer flag, enable and polarity block
`timescale 1ns/1ps
`default_nettype none
module timer_flag_monitor
  import timer_flag_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic [ADDR_W-1:0] cpu_addr,
  input wire logic cpu_rd,
  input wire logic cpu_wr,
  input wire logic cpu_wide,
  input wire logic [WIDE_W-1:0] cpu_rdata,
  input wire logic cpu_rvalid,
  input wire logic cpu_refused,
  input wire logic cpu_busy,
  input wire logic wide_rd,
  input wire logic wide_wr,
  input wire logic [WIDE_W-1:0] wide_rdata,
  input wire logic [NUM_CH-1:0][NUM_CMP-1:0] compare_match,
  input wire logic [NUM_CH-1:0] counter_overflow,
  input wire logic [NUM_CH-1:0] pwm_mode,
  input wire logic [NUM_CH-1:0] overflow_irq_request,
  input wire logic [NUM_CH-1:0] match_irq_request_a,
  input wire logic [NUM_CH-1:0] wave_pin_b
);
  logic take;   // Request accepted this cycle
  logic in_win; // Address lies in the 16-bit register window
  assign take = (cpu_rd | cpu_wr) & ~cpu_busy;
  assign in_win = (cpu_addr >= IDX_WIDE_FIRST) && (cpu_addr <= IDX_WIDE_LAST);

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  ////////////////////////////////////////////////////////////////////////////////
  // Bus answers
  chk_busy_single: assert property (cpu_busy |=> !cpu_busy)
    else $error("busy too long");
  chk_wide_answer: assert property (wide_rd |-> cpu_busy ##1
    (cpu_rvalid && cpu_rdata == $past(wide_rdata))) else $error("wide answer");
  chk_wide_request: assert property (take && cpu_rd && cpu_wide && in_win |=> wide_rd && !cpu_refused)
    else $error("wide not sent");
  chk_byte_refuse: assert property (take && !cpu_wide && in_win |=> cpu_refused && !wide_rd && !wide_wr)
    else $error("not refused");
  chk_byte_answer: assert property (take && cpu_rd && cpu_addr <= IDX_POL_CH1 |=>
    cpu_rvalid && !cpu_refused && cpu_rdata[15:8] == 8'h00) else $error("byte answer");

  ////////////////////////////////////////////////////////////////////////////////
  // Requests move two cycles after a cause
  chk_over_rise: assert property ($rose(overflow_irq_request[0]) |->
    $past(cpu_wr, 2) || $past(counter_overflow[0], 2)) else $error("request rose");
  chk_clear_fall: assert property ($fell(match_irq_request_a[0]) |-> $past(cpu_wr, 2))
    else $error("request fell");

  // Match A then duty match flips the pin
  sequence a_then_b;
    pwm_mode[0] && compare_match[0] == 4'h1 && !cpu_wr ##1 pwm_mode[0] && compare_match[0] == 4'h2 && !cpu_wr;
  endsequence
  chk_pwm_pair: assert property (a_then_b |=> wave_pin_b[0] != $past(wave_pin_b[0]))
    else $error("pin kept");
  chk_pwm_hold: assert property (!pwm_mode[0] |=> $stable(wave_pin_b[0]))
    else $error("pin moved");

  cov_wide_read: cover property (wide_rd);
  cov_refused: cover property (cpu_refused);
  cov_ovf_irq: cover property ($rose(overflow_irq_request[0]));
endmodule : timer_flag_monitor
`default_nettype wire

// [verification/wide_regs_model.sv]
// Model of the counter logic that holds the 16-bit registers
`timescale 1ns/1ps
`default_nettype none
module wide_regs_model
  import timer_flag_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic wide_rd,
  input wire logic wide_wr,
  input wire logic [WIDE_IDX_W-1:0] wide_index,
  input wire logic [WIDE_W-1:0] wide_wdata,
  output logic [WIDE_W-1:0] wide_rdata
);
  logic [WIDE_W-1:0] words [10]; // Counter and A-D per channel

  // Whole-word writes only; there are no byte lanes here
  always_ff @(posedge clock)
  begin
    if (srst)
      words <= '{default: '0};
    else if (wide_wr)
      words[wide_index] <= wide_wdata;
  end

  // Data is only good while the strobe stands
  assign wide_rdata = wide_rd ? words[wide_index] : ~words[wide_index];
endmodule : wide_regs_model
`default_nettype wire

// [verification/test_timer_flag_irq_polarity_regs.sv]
// Self-checking bench for the timer flag, enable and polarity block
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) \
  checked++; \
  if ((got) !== (exp)) \
  begin \
    num_errors++; \
    $display("[FAIL] %s expected %h seen %h", what, exp, got); \
  end
module test_timer_flag_irq_polarity_regs
  import timer_flag_pkg::*;
;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [ADDR_W-1:0] cpu_addr = '0;
  logic cpu_rd = 1'b0, cpu_wr = 1'b0, cpu_wide = 1'b0;
  logic [WIDE_W-1:0] cpu_wdata = '0, cpu_rdata, wide_wdata, wide_rdata;
  logic cpu_rvalid, cpu_refused, cpu_busy, wide_rd, wide_wr;
  logic [WIDE_IDX_W-1:0] wide_index;
  logic [NUM_CH-1:0][NUM_CMP-1:0] compare_match = '0, capture_event = '0, cmp_is_capture = '0;
  logic [NUM_CH-1:0] counter_overflow = '0, pwm_mode = '0;
  logic channel1_counter_underflow = 1'b0;
  logic [NUM_CH-1:0] overflow_irq_request, match_irq_request_a, match_irq_request_b;
  logic [NUM_CH-1:0] match_irq_request_c, match_irq_request_d, wave_pin_b, wave_pin_c, wave_pin_d;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;
  logic [15:0] rdv; // Last read data
  logic rfv;        // Last refused flag

  timer_flag_irq_polarity_regs timer_flag_irq_polarity_regs_i (.*);
  wide_regs_model wide_regs_model_i (.*);

  always #25 clock = ~clock;

  // Hang guard, far above the run's length
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (num_errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  // One access from a falling edge; a wide read waits out busy
  task automatic bus(input logic [4:0] a, input logic wr, input logic wd, input logic [15:0] d);
    cpu_addr = a;
    cpu_rd = ~wr;
    cpu_wr = wr;
    cpu_wide = wd;
    cpu_wdata = d;
    @(negedge clock);
    cpu_rd = 1'b0;
    cpu_wr = 1'b0;
    rfv = cpu_refused;
    if (cpu_busy)
      @(negedge clock);
    rdv = cpu_rdata;
    if (!wr)
    begin
      `CHK("rvalid", 1'b1, cpu_rvalid)
    end
  endtask : bus

  task automatic expect_reg(input logic [4:0] a, input logic [7:0] e);
    bus(a, 1'b0, 1'b0, '0);
    `CHK("byte reg", {8'h00, e}, rdv)
  endtask : expect_reg

  // One-cycle event pulse
  task automatic pulse(input logic [7:0] cm, input logic [7:0] ce, input logic [1:0] ov, input logic uf);
    {compare_match, capture_event, counter_overflow, channel1_counter_underflow} = {cm, ce, ov, uf};
    @(negedge clock);
    {compare_match, capture_event, counter_overflow, channel1_counter_underflow} = '0;
  endtask : pulse

  function automatic logic [3:0] irq_vec();
    return {match_irq_request_d[0], match_irq_request_c[0], match_irq_request_b[0], match_irq_request_a[0]};
  endfunction : irq_vec

  function automatic logic [5:0] pins();
    return {wave_pin_d[1], wave_pin_c[1], wave_pin_b[1], wave_pin_d[0], wave_pin_c[0], wave_pin_b[0]};
  endfunction : pins

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [7:0] tab [6] = '{8'hE0, 8'hC0, 8'hE0, 8'hE0, 8'hF8, 8'hF8};
    for (int i = 0; i < 6; i++)
      expect_reg(5'(i), tab[i]);
  endtask : t_reset

  task automatic t_regs();
    for (int ch = 0; ch < 2; ch++)
    begin
      bus(IDX_IER_CH0 + 5'(ch), 1'b1, 1'b0, 16'h00FF);
      expect_reg(IDX_IER_CH0 + 5'(ch), 8'hFF);
      bus(IDX_POL_CH0 + 5'(ch), 1'b1, 1'b1, 16'hFF05);
      expect_reg(IDX_POL_CH0 + 5'(ch), 8'hFD);
      bus(IDX_IER_CH0 + 5'(ch), 1'b1, 1'b0, 16'h0000);
      expect_reg(IDX_IER_CH0 + 5'(ch), 8'hE0);
    end
  endtask : t_regs

  // Wrong-mode events ignored; clear needs a read of one
  task automatic t_flags();
    logic [7:0] base;
    logic [7:0] ev;
    for (int ch = 0; ch < 2; ch++)
      for (int n = 0; n < 4; n++)
      begin
        base = ch ? 8'hC0 : 8'hE0;
        ev = 8'h01 << (4 * ch + n);
        cmp_is_capture = '0;
        pulse(8'h00, ev, 2'h0, 1'b0);
        expect_reg(5'(ch), base);
        pulse(ev, 8'h00, 2'h0, 1'b0);
        bus(5'(ch), 1'b1, 1'b0, 16'h0000);
        expect_reg(5'(ch), base | (8'h01 << n));
        bus(5'(ch), 1'b1, 1'b0, 16'h0000);
        expect_reg(5'(ch), base);
        cmp_is_capture = '1;
        pulse(ev, 8'h00, 2'h0, 1'b0);
        expect_reg(5'(ch), base);
        pulse(8'h00, ev, 2'h0, 1'b0);
        expect_reg(5'(ch), base | (8'h01 << n));
        bus(5'(ch), 1'b1, 1'b0, 16'h0000);
        expect_reg(5'(ch), base);
      end
    cmp_is_capture = '0;
  endtask : t_flags

  task automatic t_over();
    bus(IDX_IER_CH1, 1'b1, 1'b0, 16'h0010);
    pulse(8'h00, 8'h00, 2'h0, 1'b1);
    @(negedge clock);
    `CHK("over req", 2'h2, overflow_irq_request)
    expect_reg(IDX_STATUS_CH0, 8'hE0);
    expect_reg(IDX_STATUS_CH1, 8'hE0);
    pulse(8'h00, 8'h00, 2'h1, 1'b0);
    @(negedge clock);
    `CHK("over mask", 2'h2, overflow_irq_request)
    expect_reg(IDX_STATUS_CH0, 8'hF0);
    bus(IDX_IER_CH0, 1'b1, 1'b0, 16'h0010);
    @(negedge clock);
    `CHK("over on", 2'h3, overflow_irq_request)
    bus(IDX_STATUS_CH1, 1'b1, 1'b0, 16'h0000);
    bus(IDX_STATUS_CH0, 1'b1, 1'b0, 16'h0000);
    @(negedge clock);
    `CHK("over clr", 2'h0, overflow_irq_request)
  endtask : t_over

  task automatic t_irq();
    pulse(8'h0F, 8'h00, 2'h0, 1'b0);
    for (int n = 0; n < 4; n++)
    begin
      bus(IDX_IER_CH0, 1'b1, 1'b0, 16'h0001 << n);
      @(negedge clock);
      `CHK("match req", 4'h1 << n, irq_vec())
    end
    bus(IDX_IER_CH0, 1'b1, 1'b0, 16'h0000);
    @(negedge clock);
    `CHK("match off", 4'h0, irq_vec())
  endtask : t_irq

  // A clear landing with a new match keeps the flag
  task automatic t_setwins();
    expect_reg(IDX_STATUS_CH0, 8'hEF);
    bus(IDX_STATUS_CH0, 1'b1, 1'b0, 16'h0000);
    expect_reg(IDX_STATUS_CH0, 8'hE0);
    pulse(8'h01, 8'h00, 2'h0, 1'b0);
    expect_reg(IDX_STATUS_CH0, 8'hE1);
    compare_match = 8'h01;
    bus(IDX_STATUS_CH0, 1'b1, 1'b0, 16'h0000);
    compare_match = '0;
    expect_reg(IDX_STATUS_CH0, 8'hE1);
  endtask : t_setwins

  task automatic t_wide();
    bus(5'h12, 1'b1, 1'b1, 16'hA5C3);
    bus(5'h12, 1'b0, 1'b1, 16'h0000);
    `CHK("wide read", 16'hA5C3, rdv)
    bus(5'h12, 1'b0, 1'b0, 16'h0000);
    `CHK("rd refused", 1'b1, rfv)
    `CHK("rd zero", 16'h0000, rdv)
    bus(5'h12, 1'b1, 1'b0, 16'h0011);
    `CHK("wr refused", 1'b1, rfv)
    bus(5'h12, 1'b0, 1'b1, 16'h0000);
    `CHK("wide kept", 16'hA5C3, rdv)
    bus(5'h08, 1'b0, 1'b0, 16'h0000);
    `CHK("unmapped", 1'b1, rfv)
  endtask : t_wide

  // Match A then duty match, both polarities
  task automatic t_pwm();
    logic [2:0] e;
    logic [5:0] hold;
    pwm_mode = 2'h3;
    for (int p = 0; p < 2; p++)
      for (int j = 1; j < 4; j++)
      begin
        bus(IDX_POL_CH0, 1'b1, 1'b0, {16{p[0]}});
        bus(IDX_POL_CH1, 1'b1, 1'b0, {16{p[0]}});
        e = {3{~p[0]}} ^ (3'h1 << (j - 1));
        compare_match = 8'h11;
        @(negedge clock);
        compare_match = {2{4'h1 << j}};
        `CHK("pins A", {6{~p[0]}}, pins())
        @(negedge clock);
        compare_match = '0;
        `CHK("pins duty", {e, e}, pins())
      end
    pwm_mode = '0;
    hold = pins();
    pulse(8'hFF, 8'h00, 2'h0, 1'b0);
    `CHK("pins hold", hold, pins())
  endtask : t_pwm

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(negedge clock);
    srst = 1'b0;
    @(negedge clock);
    t_reset();
    t_regs();
    t_flags();
    t_over();
    t_irq();
    t_setwins();
    t_wide();
    t_pwm();
    srst = 1'b1;
    repeat (2) @(negedge clock);
    srst = 1'b0;
    @(negedge clock);
    t_reset();
    wrap_up();
  end
endmodule : test_timer_flag_irq_polarity_regs

bind timer_flag_irq_polarity_regs timer_flag_monitor timer_flag_monitor_i (.*);
`default_nettype wire
